/* hw/pcwd_decoder.sv */
// Proxy control word decoder and parameter re-apply engine
`default_nettype none
module pcwd_decoder
  import pcwd_pkg::*;
#(
  parameter int unsigned DEPTH = PARAM_DEPTH
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // Cyclic command word from the controller
  input  wire logic              word_valid,
  input  wire pcwd_word_t        word,
  input  wire logic              proxy_mode,
  // Sensor configuration and capabilities
  input  wire pcwd_src_t         src,
  input  wire pcwd_cap_t         cap,
  // Controller module list
  input  wire logic              mod_valid,
  input  wire pcwd_mod_t         mod_kind,
  input  wire logic [15:0]       mod_data,
  // Connection events
  input  wire logic              fb_restart,
  input  wire logic              local_cfg_changed,
  // Sensor command outputs
  output logic                   trig_q,
  output logic                   read_start_q,
  output logic                   read_stop_q,
  output logic                   sleep_q,
  output logic                   teach1_start_q,
  output logic                   teach2_start_q,
  output logic [FOCUS_W-1:0]     focus_q,
  output logic                   focus_change_q,
  // Parameter stream to the sensor
  output logic                   cfg_valid,
  input  wire logic              cfg_ready,
  output logic [15:0]            cfg_data_q,
  output logic                   cfg_done_q,
  output logic                   local_lost_q,
  // Status
  output logic                   params_present_q,
  output logic                   local_dirty_q
);

  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef enum logic {
    PCWD_IDLE,
    PCWD_APPLY
  } pcwd_state_t;

  // ----------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------

  // Mask of bits allowed to act under the current mode and config
  function automatic logic [WORD_W-1:0] act_mask(input logic pm, input pcwd_src_t s,
                                                 input pcwd_cap_t c);
    logic [WORD_W-1:0] m;
    m = '0;
    m[TRIG_BIT]   = pm & s.trig_fb;
    m[SLEEP_BIT]  = pm & s.sleep_fb & c.sleep;
    m[TEACH1_BIT] = pm & s.teach1_fb & c.teach1;
    m[TEACH2_BIT] = pm & s.teach2_fb & c.teach2;
    m[FOCUS_LSB +: FOCUS_W] = {FOCUS_W{pm & s.focus_fb & c.focus}};
    return m;
  endfunction : act_mask

  logic [WORD_W-1:0] raw_w;
  logic [WORD_W-1:0] eff_w;
  logic [WORD_W-1:0] cmd_q;

  // Base byte carries the high bits, next byte the low bits
  assign raw_w = {word.base_byte, word.next_byte};
  assign eff_w = raw_w & act_mask(proxy_mode, src, cap);

  // Effective command word, updated once per cyclic output update
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cmd_q <= CMD_RESET;
    end else if (word_valid) begin
      cmd_q <= eff_w;
    end
  end

  // Level outputs follow the stored command word
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      trig_q  <= 1'b0;
      sleep_q <= 1'b0;
      focus_q <= FOCUS_RESET;
    end else if (word_valid) begin
      trig_q  <= eff_w[TRIG_BIT];
      sleep_q <= eff_w[SLEEP_BIT];
      focus_q <= eff_w[FOCUS_LSB +: FOCUS_W];
    end
  end

  // Edge pulses between successive updates
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      read_start_q   <= 1'b0;
      read_stop_q    <= 1'b0;
      teach1_start_q <= 1'b0;
      teach2_start_q <= 1'b0;
      focus_change_q <= 1'b0;
    end else begin
      read_start_q   <= word_valid & eff_w[TRIG_BIT] & ~cmd_q[TRIG_BIT];
      read_stop_q    <= word_valid & ~eff_w[TRIG_BIT] & cmd_q[TRIG_BIT]
                        & src.stop_by_trig;
      teach1_start_q <= word_valid & eff_w[TEACH1_BIT] & ~cmd_q[TEACH1_BIT];
      teach2_start_q <= word_valid & eff_w[TEACH2_BIT] & ~cmd_q[TEACH2_BIT];
      focus_change_q <= word_valid
                        & (eff_w[FOCUS_LSB +: FOCUS_W] != cmd_q[FOCUS_LSB +: FOCUS_W]);
    end
  end

  // ----------------------------------------------------------------
  // Parameter module capture
  // ----------------------------------------------------------------
  logic [15:0]   param_mem [DEPTH];
  logic          loading_q;
  logic [CW-1:0] load_cnt_q;
  logic [CW-1:0] param_cnt_q;

  // Parameters count only between an open and a close module
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      loading_q        <= 1'b0;
      load_cnt_q       <= '0;
      param_cnt_q      <= '0;
      params_present_q <= 1'b0;
    end else if (mod_valid) begin
      unique case (mod_kind)
        MOD_CFG_OPEN: begin
          loading_q  <= 1'b1;
          load_cnt_q <= '0;
        end
        MOD_PARAM: begin
          if (loading_q && load_cnt_q < CW'(DEPTH)) begin
            load_cnt_q <= load_cnt_q + CW'(1);
          end
        end
        MOD_CFG_CLOSE: begin
          if (loading_q) begin
            loading_q        <= 1'b0;
            param_cnt_q      <= load_cnt_q;
            params_present_q <= (load_cnt_q != '0);
          end
        end
        MOD_OTHER: begin
          loading_q <= 1'b0;                               // Open set broken off
        end
      endcase
    end
  end

  logic [15:0]   stage_mem [DEPTH];

  // Incoming words are staged so a broken-off set leaves the stored one whole
  always_ff @(posedge clock) begin
    if (mod_valid && mod_kind == MOD_PARAM && loading_q && load_cnt_q < CW'(DEPTH)) begin
      stage_mem[load_cnt_q[CW-1:0] % DEPTH] <= mod_data;
    end
  end

  // Parameter words kept for every later restart, taken over at the close
  always_ff @(posedge clock) begin
    if (mod_valid && mod_kind == MOD_CFG_CLOSE && loading_q) begin
      param_mem <= stage_mem;
    end
  end

  // ----------------------------------------------------------------
  // Re-apply at fieldbus restart
  // ----------------------------------------------------------------
  pcwd_state_t   state_q;
  logic [CW-1:0] idx_q;
  logic          apply_go;
  logic          apply_last;

  assign apply_go   = (state_q == PCWD_IDLE) & fb_restart & params_present_q;
  assign apply_last = (state_q == PCWD_APPLY) & cfg_ready & (idx_q == param_cnt_q - CW'(1));
  assign cfg_valid  = (state_q == PCWD_APPLY);

  // Walk the stored parameter set into the sensor
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q    <= PCWD_IDLE;
      idx_q      <= '0;
      cfg_data_q <= 16'h0000;
      cfg_done_q <= 1'b0;
    end else begin
      cfg_done_q <= apply_last;
      unique case (state_q)
        PCWD_IDLE: begin
          if (apply_go) begin
            state_q    <= PCWD_APPLY;
            idx_q      <= '0;
            cfg_data_q <= param_mem[0];
          end
        end
        PCWD_APPLY: begin
          if (apply_last) begin
            state_q <= PCWD_IDLE;
          end else if (cfg_ready) begin
            idx_q      <= idx_q + CW'(1);
            cfg_data_q <= param_mem[(idx_q + CW'(1)) % DEPTH];
          end
        end
      endcase
    end
  end

  // Local changes are marked and later overwritten; a new change wins
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      local_dirty_q <= 1'b0;
      local_lost_q  <= 1'b0;
    end else begin
      local_lost_q <= apply_last & local_dirty_q;
      if (local_cfg_changed) begin
        local_dirty_q <= 1'b1;
      end else if (apply_last) begin
        local_dirty_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_trig_rise;
    word_valid && eff_w[TRIG_BIT] && !cmd_q[TRIG_BIT];
  endsequence

  sequence s_trig_fall;
    word_valid && !eff_w[TRIG_BIT] && cmd_q[TRIG_BIT] && src.stop_by_trig;
  endsequence

  property p_source_gate;
    word_valid && !src.trig_fb |=> !trig_q && !read_start_q;
  endproperty
  a_source_gate: assert property (p_source_gate) else $error("trigger acted without source");

  property p_gateway_quiet;
    word_valid && !proxy_mode |=> !trig_q && !sleep_q && focus_q == 4'h0 && !teach1_start_q
                                  && !teach2_start_q;
  endproperty
  a_gateway_quiet: assert property (p_gateway_quiet) else $error("gateway word acted");

  property p_byte_order;
    word_valid && proxy_mode && src.trig_fb |=> trig_q == $past(word.next_byte[0]);
  endproperty
  a_byte_order: assert property (p_byte_order) else $error("trigger not from low byte");

  property p_start;
    s_trig_rise |=> read_start_q ##1 !read_start_q;
  endproperty
  a_start: assert property (p_start) else $error("read start pulse wrong");

  property p_stop;
    s_trig_fall |=> read_stop_q && !trig_q;
  endproperty
  a_stop: assert property (p_stop) else $error("read stop pulse missing");

  property p_sleep_cap;
    word_valid && !cap.sleep |=> !sleep_q;
  endproperty
  a_sleep_cap: assert property (p_sleep_cap) else $error("sleep without support");

  property p_unused_bits;
    cmd_q[UNUSED_MSB:UNUSED_LSB] == 8'h00;
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("ignored bits stored");

  property p_focus;
    word_valid && proxy_mode && src.focus_fb && cap.focus
      |=> focus_q == $past(word.base_byte[7:4]);
  endproperty
  a_focus: assert property (p_focus) else $error("focus selector wrong");

  property p_teach1;
    word_valid && !(proxy_mode && src.teach1_fb && cap.teach1) |=> !teach1_start_q;
  endproperty
  a_teach1: assert property (p_teach1) else $error("teach-in one without cause");

  property p_restart;
    apply_go |=> cfg_valid && idx_q == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not reapply");

  property p_overwrite;
    apply_last && local_dirty_q |=> local_lost_q && cfg_done_q;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("local change not reported");

endmodule : pcwd_decoder
`default_nettype wire

/* hw/pcwd_pkg.sv */
// Shared constants and types of the proxy control word decoder
`default_nettype none
package pcwd_pkg;

  // ----------------------------------------------------------------
  // Bit positions within the 16-bit command word (D0 = bit 0)
  // ----------------------------------------------------------------
  localparam int unsigned TRIG_BIT      = 0;
  localparam int unsigned SLEEP_BIT     = 1;
  localparam int unsigned TEACH1_BIT    = 2;
  localparam int unsigned TEACH2_BIT    = 3;
  localparam int unsigned UNUSED_LSB    = 4;
  localparam int unsigned UNUSED_MSB    = 11;
  localparam int unsigned FOCUS_LSB     = 12;
  localparam int unsigned FOCUS_W       = 4;
  localparam int unsigned WORD_W        = 16;

  // ----------------------------------------------------------------
  // Values after reset and parameter store defaults
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_RESET     = 16'h0000;
  localparam logic [3:0]  FOCUS_RESET   = 4'h0;
  localparam int unsigned PARAM_DEPTH   = 8;

  // Command word as two bytes: base address byte holds D15..D8,
  // base address plus one holds D7..D0
  typedef struct packed {
    logic [7:0] base_byte;
    logic [7:0] next_byte;
  } pcwd_word_t;

  // Sensor functions configured to take their source from the fieldbus
  typedef struct packed {
    logic trig_fb;
    logic stop_by_trig;
    logic sleep_fb;
    logic teach1_fb;
    logic teach2_fb;
    logic focus_fb;
  } pcwd_src_t;

  // Optional functions that the attached sensor supports
  typedef struct packed {
    logic sleep;
    logic teach1;
    logic teach2;
    logic focus;
  } pcwd_cap_t;

  // Kinds of module in the controller's module list
  typedef enum logic [1:0] {
    MOD_OTHER,
    MOD_CFG_OPEN,
    MOD_PARAM,
    MOD_CFG_CLOSE
  } pcwd_mod_t;

endpackage : pcwd_pkg
`default_nettype wire

/* testbench/pcwd_sensor_model.sv */
// Behavioural sensor that takes the re-applied parameter stream
`default_nettype none
module pcwd_sensor_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Parameter stream
  input  wire logic        cfg_valid,
  input  wire logic [15:0] cfg_data_q,
  output logic             cfg_ready,
  // Pacing chosen by the bench
  input  wire logic        slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] got [0:31];
  int          n;
  // Ready every cycle, or every other cycle when slow
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfg_ready <= 1'b0;
    end else begin
      cfg_ready <= slow ? ~cfg_ready : 1'b1;
    end
  end
  // Accepted words are logged in arrival order
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      n <= 0;
    end else if (cfg_valid && cfg_ready) begin
      got[n[4:0]] <= cfg_data_q;
      n           <= n + 1;
    end
  end
endmodule : pcwd_sensor_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench of the proxy control word decoder
`default_nettype none
module testbench;
  import pcwd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, reset = 1'b1, word_valid = 1'b0, proxy_mode = 1'b1;
  logic mod_valid = 1'b0, fb_restart = 1'b0, local_cfg_changed = 1'b0, slow = 1'b0;
  pcwd_word_t  word = 16'h0000;
  pcwd_src_t   src = 6'h3F;
  pcwd_cap_t   cap = 4'hF;
  pcwd_mod_t   mod_kind = MOD_OTHER;
  logic [15:0] mod_data = 16'h0000, cfg_data_q;
  logic trig_q, read_start_q, read_stop_q, sleep_q, teach1_start_q, teach2_start_q;
  logic focus_change_q, cfg_valid, cfg_ready, cfg_done_q, local_lost_q;
  logic params_present_q, local_dirty_q;
  logic [3:0]  focus_q;
  logic [15:0] obs;
  int          failures = 0, compares = 0, n0;
  // Clock at 20 MHz
  always #25 clock = ~clock;
  assign obs = {5'h00, trig_q, read_start_q, read_stop_q, sleep_q, teach1_start_q,
                teach2_start_q, focus_q, focus_change_q};
  pcwd_decoder #(.DEPTH(4)) dut_u (.clock(clock), .reset(reset), .word_valid(word_valid),
    .word(word), .proxy_mode(proxy_mode), .src(src), .cap(cap), .mod_valid(mod_valid),
    .mod_kind(mod_kind), .mod_data(mod_data), .fb_restart(fb_restart),
    .local_cfg_changed(local_cfg_changed), .trig_q(trig_q), .read_start_q(read_start_q),
    .read_stop_q(read_stop_q), .sleep_q(sleep_q), .teach1_start_q(teach1_start_q),
    .teach2_start_q(teach2_start_q), .focus_q(focus_q), .focus_change_q(focus_change_q),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_data_q(cfg_data_q),
    .cfg_done_q(cfg_done_q), .local_lost_q(local_lost_q),
    .params_present_q(params_present_q), .local_dirty_q(local_dirty_q));
  pcwd_sensor_model sen_u (.clock(clock), .reset(reset), .cfg_valid(cfg_valid),
    .cfg_data_q(cfg_data_q), .cfg_ready(cfg_ready), .slow(slow));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] ex(input int t, s, p, l, a, b, input logic [3:0] f,
                                     input int c);
    ex = {5'h00, t[0], s[0], p[0], l[0], a[0], b[0], f, c[0]};
  endfunction : ex
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One cyclic update; returns in the cycle that shows its answer
  task automatic send(input logic [15:0] w);
    @(negedge clock) word = w;
    word_valid = 1'b1;
    @(negedge clock) word_valid = 1'b0;
  endtask : send
  task automatic put(input pcwd_mod_t k, input logic [15:0] d);
    @(negedge clock) mod_kind = k;
    mod_data = d;
    mod_valid = 1'b1;
    @(negedge clock) mod_valid = 1'b0;
  endtask : put
  // Restart, then wait for the stream to finish
  task automatic restart(input logic lost);
    n0 = sen_u.n;
    @(negedge clock) fb_restart = 1'b1;
    @(negedge clock) fb_restart = 1'b0;
    for (int k = 0; k < 40 && cfg_done_q !== 1'b1; k++) @(negedge clock);
    chk(16'(cfg_done_q), 16'h0001);
    chk(16'(local_lost_q), 16'(lost));
    chk(16'(sen_u.n - n0), 16'h0002);
    chk(sen_u.got[n0[4:0]], 16'h1234);
    chk(sen_u.got[5'(n0 + 1)], 16'hABCD);
    chk(16'(local_dirty_q), 16'h0000);
  endtask : restart
  task automatic summarize;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clock);
    reset = 1'b0;
    chk(obs | 16'(params_present_q), 16'h0000);
    send(16'h0001); chk(obs, ex(1, 1, 0, 0, 0, 0, 4'h0, 0));
    send(16'h0000); chk(obs, ex(0, 0, 1, 0, 0, 0, 4'h0, 0));
    send(16'hAFFE); chk(obs, ex(0, 0, 0, 1, 1, 1, 4'hA, 1));
    send(16'hAFF0); chk(obs, ex(0, 0, 0, 0, 0, 0, 4'hA, 0));
    $display("test command bits done");
    proxy_mode = 1'b0;
    send(16'hFFFF);
    send(16'hFFFF); chk(obs, ex(0, 0, 0, 0, 0, 0, 4'h0, 0));
    proxy_mode = 1'b1;
    for (int i = 0; i < 2; i++) begin
      src = (i == 1) ? 6'h3F : 6'h00;
      cap = (i == 1) ? 4'h0 : 4'hF;
      send(16'hFFFF); chk(obs, ex(i[0], i[0], 0, 0, 0, 0, 4'h0, 0));
      send(16'h0000);
    end
    src = 6'h2F;
    cap = 4'hF;
    send(16'h0001); chk(obs, ex(1, 1, 0, 0, 0, 0, 4'h0, 0));
    send(16'h0000); chk(obs, ex(0, 0, 0, 0, 0, 0, 4'h0, 0));
    $display("test masking done");
    put(MOD_PARAM, 16'h1111);
    put(MOD_CFG_OPEN, 16'h0000);
    put(MOD_PARAM, 16'h1234);
    put(MOD_PARAM, 16'hABCD);
    put(MOD_CFG_CLOSE, 16'h0000); chk(16'(params_present_q), 16'h0001);
    @(negedge clock) local_cfg_changed = 1'b1;
    @(negedge clock) local_cfg_changed = 1'b0;
    chk(16'(local_dirty_q), 16'h0001);
    restart(1'b1);
    put(MOD_CFG_OPEN, 16'h0000);
    put(MOD_PARAM, 16'h5555);
    put(MOD_OTHER, 16'h0000);
    slow = 1'b1;
    restart(1'b0);
    $display("test re-apply done");
    summarize();
  end
  // Watchdog far beyond the roughly sixty cycles of the tests
  initial begin
    #(5000 * 50);
    failures++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
